/* interrupt_pending_priority_map.svh */
`ifndef INTERRUPT_PENDING_PRIORITY_MAP_SVH
`define INTERRUPT_PENDING_PRIORITY_MAP_SVH

// Byte addresses of the registers on the APB.
`define SRC_LATCH_ADDR 32'h4a000000
`define FAST_SEL_ADDR 32'h4a000004
`define MASK_ADDR 32'h4a000008
`define PRIORITY_ADDR 32'h4a00000c
`define GRANT_PEND_ADDR 32'h4a000010
`define GRANT_INDEX_ADDR 32'h4a000014

// Reset values.
`define SRC_LATCH_RESET 32'h00000000
`define FAST_SEL_RESET 32'h00000000
`define MASK_RESET 32'hffffffff
`define ROTATE_EN_RESET 7'h7f
`define ORDER_SEL_RESET 14'h0000
`define GRANT_PEND_RESET 32'h00000000
`define GRANT_INDEX_RESET 5'h00

// Priority register field positions.
`define ROTATE_EN_LSB 0
`define ROTATE_EN_MSB 6
`define ORDER_SEL_LSB 7
`define ORDER_SEL_MSB 20

// Order-select codes.
`define ORDER_SEL_1 2'h1
`define ORDER_SEL_2 2'h2
`define ORDER_SEL_3 2'h3
`define ORDER_SEL_4 2'h0

`endif

/* interrupt_pending_priority_pkg.sv */
package interrupt_pending_priority_pkg;

  typedef struct packed {
    logic [10:0] unused;
    logic [6:0][1:0] order_select;
    logic [6:0] rotate_enable;
  } priority_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [2:0] idx;
  } arb_grant_t;

endpackage

/* interrupt_pending_priority_core.sv */
// Contract
// - Seven rotating arbiters resolve 32 requests: six groups and a top.
// - Each arbiter has inputs 0 to 5, a rotate enable and order select.
// - Order select 00 ranks 0,1,2,3,4,5; 01 ranks 0,2,3,4,1,5.
// - Order select 10 ranks 0,3,4,1,2,5; 11 ranks 0,4,1,2,3,5.
// - Input 0 always wins, input 5 always loses; only 1 to 4 rotate.
// - Rotate enable low: hardware keeps order select; software may rewrite.
// - Rotate enable high: serviced input drops to lowest rank among 1 to 4.
// - Servicing input 0 or 5 leaves order select unchanged.
// - Servicing input 1 loads 01, servicing input 2 loads 10.
// - Servicing input 3 loads 11, servicing input 4 loads 00.
// - Requests latch first, split fast or normal; only normal arbitrate.
// - A pending bit sets on request regardless of mask and stays set.
// - Pending bits do not depend on arbitration; losers stay set.
// - A pending bit still set counts as a fresh request.
// - Writing the pending register clears only the bits written as one.
// - Pending register resets to zero; a one means requested.
// - Bits map one per source, line 0 at bit 0, converter at 31.
// - Mode bit one routes to fast output, zero to normal; resets zero.
// - Fast sources never update granted pending or granted index.
// - Only the single winner sets granted pending and drives normal output.
// - Masked sources still latch but are not serviced; mask resets to ones.
// - Priority register resets with rotate enables one, order selects zero.
`timescale 1ns/1ps
`include "interrupt_pending_priority_map.svh"

module interrupt_pending_priority_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] src_request,
  output logic fast_interrupt_request,
  output logic normal_interrupt_request
);

  logic [31:0] source_request_latch_reg;
  logic [31:0] fast_path_select_reg;
  logic [31:0] source_mask_bits_reg;
  logic [31:0] granted_pending_reg;
  logic [4:0] granted_index_reg;
  logic fast_irq_reg;
  interrupt_pending_priority_pkg::priority_ctrl_t priority_reg;

  logic setup_phase;
  logic access_phase;
  logic addr_mapped;
  logic wr_src;
  logic wr_fast;
  logic wr_mask;
  logic wr_prio;
  logic wr_grant;
  logic [31:0] normal_req;
  logic [5:0][5:0] group_req;
  interrupt_pending_priority_pkg::arb_grant_t [5:0] group_win;
  logic [5:0] top_req;
  interrupt_pending_priority_pkg::arb_grant_t top_win;
  logic [4:0] win_src;
  logic grant_fire;

  // Ranks inputs 1 to 4 starting at sel plus one; 0 first and 5 last.
  function automatic interrupt_pending_priority_pkg::arb_grant_t arbitrate(
    input logic [5:0] req,
    input logic [1:0] sel
  );
    interrupt_pending_priority_pkg::arb_grant_t r;
    logic [1:0] k;
    logic [2:0] cand;
    r = '0;
    k = 2'h0;
    cand = 3'h0;
    if (req[0]) begin
      r = {1'b1, 3'h0};
    end else begin
      for (int i = 3; i >= 0; i--) begin
        k = sel + 2'(i);
        cand = {1'b0, k} + 3'h1;
        if (req[cand]) begin
          r = {1'b1, cand};
        end
      end
      if (!r.valid && req[5]) begin
        r = {1'b1, 3'h5};
      end
    end
    return r;
  endfunction

  // New order select after input idx is serviced.
  function automatic logic [1:0] rotated(
    input logic [1:0] sel,
    input logic [2:0] idx
  );
    logic [1:0] r;
    unique case (idx)
      3'h1: r = `ORDER_SEL_1;
      3'h2: r = `ORDER_SEL_2;
      3'h3: r = `ORDER_SEL_3;
      3'h4: r = `ORDER_SEL_4;
      default: r = sel;
    endcase
    return r;
  endfunction

  // Groups 0 and 5 hold four sources on inputs 1 to 4; others hold six.
  function automatic logic [5:0] group_inputs(
    input int g,
    input logic [31:0] v
  );
    logic [5:0] r;
    unique case (g)
      0: r = {1'b0, v[3:0], 1'b0};
      1: r = v[9:4];
      2: r = v[15:10];
      3: r = v[21:16];
      4: r = v[27:22];
      default: r = {1'b0, v[31:28], 1'b0};
    endcase
    return r;
  endfunction

  function automatic logic [4:0] group_source(
    input logic [2:0] g,
    input logic [2:0] idx
  );
    logic [4:0] base;
    unique case (g)
      3'h0: base = 5'h1f;
      3'h1: base = 5'h04;
      3'h2: base = 5'h0a;
      3'h3: base = 5'h10;
      3'h4: base = 5'h16;
      default: base = 5'h1b;
    endcase
    return base + {2'h0, idx};
  endfunction

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign addr_mapped = (paddr == `SRC_LATCH_ADDR) ||
                       (paddr == `FAST_SEL_ADDR) ||
                       (paddr == `MASK_ADDR) ||
                       (paddr == `PRIORITY_ADDR) ||
                       (paddr == `GRANT_PEND_ADDR) ||
                       (paddr == `GRANT_INDEX_ADDR);
  assign wr_src = access_phase & pwrite & (paddr == `SRC_LATCH_ADDR);
  assign wr_fast = access_phase & pwrite & (paddr == `FAST_SEL_ADDR);
  assign wr_mask = access_phase & pwrite & (paddr == `MASK_ADDR);
  assign wr_prio = access_phase & pwrite & (paddr == `PRIORITY_ADDR);
  assign wr_grant = access_phase & pwrite & (paddr == `GRANT_PEND_ADDR);
  assign pready = 1'b1;
  assign pslverr = access_phase & ~addr_mapped;

  // Only unmasked normal-path latched bits reach the arbiters.
  assign normal_req = source_request_latch_reg & ~fast_path_select_reg &
                      ~source_mask_bits_reg;

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gen_group
      assign group_req[g] = group_inputs(g, normal_req);
      assign group_win[g] = arbitrate(group_req[g],
                                      priority_reg.order_select[g]);
      assign top_req[g] = group_win[g].valid;
    end
  endgenerate

  assign top_win = arbitrate(top_req, priority_reg.order_select[6]);
  assign win_src = group_source(top_win.idx, group_win[top_win.idx].idx);
  // A new grant is made only once the previous one has been cleared.
  assign grant_fire = top_win.valid && (granted_pending_reg == 32'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_request_latch_reg <= `SRC_LATCH_RESET;
    end else begin
      // A request in the same cycle as a clear keeps its bit set.
      source_request_latch_reg <= (source_request_latch_reg &
                                   ~(wr_src ? pwdata : 32'h0)) |
                                  src_request;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_path_select_reg <= `FAST_SEL_RESET;
    end else if (wr_fast) begin
      fast_path_select_reg <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_mask_bits_reg <= `MASK_RESET;
    end else if (wr_mask) begin
      source_mask_bits_reg <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priority_reg.unused <= 11'h000;
      priority_reg.order_select <= `ORDER_SEL_RESET;
      priority_reg.rotate_enable <= `ROTATE_EN_RESET;
    end else if (wr_prio) begin
      priority_reg.order_select <=
        pwdata[`ORDER_SEL_MSB:`ORDER_SEL_LSB];
      priority_reg.rotate_enable <=
        pwdata[`ROTATE_EN_MSB:`ROTATE_EN_LSB];
    end else if (grant_fire) begin
      for (int i = 0; i < 6; i++) begin
        if (priority_reg.rotate_enable[i] && top_win.idx == 3'(i)) begin
          priority_reg.order_select[i] <=
            rotated(priority_reg.order_select[i], group_win[i].idx);
        end
      end
      if (priority_reg.rotate_enable[6]) begin
        priority_reg.order_select[6] <=
          rotated(priority_reg.order_select[6], top_win.idx);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      granted_pending_reg <= `GRANT_PEND_RESET;
    end else begin
      granted_pending_reg <= (granted_pending_reg &
                              ~(wr_grant ? pwdata : 32'h0)) |
                             (grant_fire ? (32'h1 << win_src)
                                         : 32'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      granted_index_reg <= `GRANT_INDEX_RESET;
    end else if (grant_fire) begin
      granted_index_reg <= win_src;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_irq_reg <= 1'b0;
    end else begin
      fast_irq_reg <= |(source_request_latch_reg & fast_path_select_reg &
                        ~source_mask_bits_reg);
    end
  end

  assign fast_interrupt_request = fast_irq_reg;
  assign normal_interrupt_request = |granted_pending_reg;

  // Read data is captured in the setup cycle and shown in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup_phase) begin
      unique case (paddr)
        `SRC_LATCH_ADDR: prdata <= source_request_latch_reg;
        `FAST_SEL_ADDR: prdata <= fast_path_select_reg;
        `MASK_ADDR: prdata <= source_mask_bits_reg;
        `PRIORITY_ADDR: prdata <= priority_reg;
        `GRANT_PEND_ADDR: prdata <= granted_pending_reg;
        `GRANT_INDEX_ADDR: prdata <= {27'h0, granted_index_reg};
        default: prdata <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_pend_set: assert property (
    (src_request != 32'h0) |=>
      ((source_request_latch_reg & $past(src_request)) ==
       $past(src_request)))
    else $error("Requested source did not latch its pending bit.");

  chk_w1c_clear: assert property (
    (wr_src && src_request == 32'h0) |=>
      (source_request_latch_reg ==
       ($past(source_request_latch_reg) & ~$past(pwdata))))
    else $error("Pending write did not clear exactly the ones written.");

  chk_grant_onehot: assert property (
    $onehot0(granted_pending_reg) &&
    (normal_interrupt_request == (granted_pending_reg != 32'h0)))
    else $error("Granted pending holds more than one bit.");

  chk_fast_excluded: assert property (
    grant_fire |=>
      ((granted_pending_reg & $past(fast_path_select_reg)) == 32'h0))
    else $error("Fast-path source reached granted pending.");

  chk_mask_blocks: assert property (
    grant_fire |=>
      ((granted_pending_reg & $past(source_mask_bits_reg)) == 32'h0) &&
      (granted_pending_reg[granted_index_reg]))
    else $error("Masked source was granted or index mismatched.");

  chk_input0_wins: assert property (
    top_req[0] |-> (top_win.valid && top_win.idx == 3'h0))
    else $error("Input 0 of the top arbiter did not win.");

  chk_fixed_hold: assert property (
    (!priority_reg.rotate_enable[6] && !wr_prio) |=>
      $stable(priority_reg.order_select[6]))
    else $error("Order select changed with rotation disabled.");

  chk_rotate_in1: assert property (
    (grant_fire && priority_reg.rotate_enable[6] && !wr_prio &&
     top_win.idx == 3'h1) |=> (priority_reg.order_select[6] == 2'h1))
    else $error("Servicing input 1 did not load order 01.");

  chk_rotate_in4: assert property (
    (grant_fire && priority_reg.rotate_enable[6] && !wr_prio &&
     top_win.idx == 3'h4) |=> (priority_reg.order_select[6] == 2'h0))
    else $error("Servicing input 4 did not load order 00.");

  chk_rotate_edge: assert property (
    (grant_fire && !wr_prio &&
     (top_win.idx == 3'h0 || top_win.idx == 3'h5)) |=>
      $stable(priority_reg.order_select[6]))
    else $error("Servicing input 0 or 5 changed the order select.");

  chk_fiq_route: assert property (
    ##1 (fast_interrupt_request ==
         $past(|(source_request_latch_reg & fast_path_select_reg &
                 ~source_mask_bits_reg))))
    else $error("Fast output does not follow fast-path pending bits.");

  chk_rotate_in2: assert property (
    (grant_fire && priority_reg.rotate_enable[6] && !wr_prio &&
     top_win.idx == 3'h2) |=> (priority_reg.order_select[6] == 2'h2))
    else $error("Servicing input 2 did not load order 10.");

  chk_rotate_in3: assert property (
    (grant_fire && priority_reg.rotate_enable[6] && !wr_prio &&
     top_win.idx == 3'h3) |=> (priority_reg.order_select[6] == 2'h3))
    else $error("Servicing input 3 did not load order 11.");

  // Group 0 carries source n on input n plus one, so the new order is n+1.
  chk_group_rotate: assert property (
    (grant_fire && !wr_prio && priority_reg.rotate_enable[0] &&
     top_win.idx == 3'h0) |=>
      (priority_reg.order_select[0] == granted_index_reg[1:0] + 2'h1))
    else $error("First-level order select did not rotate.");

  chk_fixed_group: assert property (
    (!priority_reg.rotate_enable[0] && !wr_prio) |=>
      $stable(priority_reg.order_select[0]))
    else $error("Group order select changed with rotation disabled.");

  chk_latch_hold: assert property (
    !wr_src |=>
      ((source_request_latch_reg & $past(source_request_latch_reg)) ==
       $past(source_request_latch_reg)))
    else $error("Pending bit dropped without a software clear.");

  chk_grant_hold: assert property (
    (granted_pending_reg != 32'h0 && !wr_grant) |=>
      $stable(granted_pending_reg))
    else $error("Granted pending changed while a grant was outstanding.");

endmodule

/* request_source_model.sv */
`timescale 1ns/1ps

module request_source_model (
  input wire logic pclk,
  output logic [31:0] src_request
);
  initial src_request = 32'h00000000;

  // Peripherals raise their lines for one cycle only, the shortest request.
  task automatic pulse(input logic [31:0] bits);
    @(posedge pclk);
    src_request <= bits;
    @(posedge pclk);
    src_request <= 32'h00000000;
  endtask
endmodule

/* test_interrupt_pending_priority_core.sv */
`timescale 1ns/1ps
`include "interrupt_pending_priority_map.svh"

module test_interrupt_pending_priority_core;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] src_request;
  logic fast_irq;
  logic normal_irq;
  logic [31:0] rd;
  logic err;
  logic [31:0] prev;
  logic [31:0] exp_bit [3] = '{32'h4, 32'h10, 32'h400};
  logic [31:0] exp_idx [3] = '{32'h2, 32'h4, 32'ha};
  logic [31:0] exp_pri [3] = '{32'h1ff, 32'h801ff, 32'h1001ff};
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #2 pclk = ~pclk;

  interrupt_pending_priority_core u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_request(src_request),
    .fast_interrupt_request(fast_irq),
    .normal_interrupt_request(normal_irq)
  );

  request_source_model u_src (.pclk(pclk), .src_request(src_request));

  task report_and_stop;
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h00000000);
    check(rd, exp);
  endtask

  task settle;
    repeat (4) @(posedge pclk);
  endtask

  // The latch bit is cleared before the granted bit.
  task service(input logic [31:0] bits);
    apb(1'b1, `SRC_LATCH_ADDR, bits);
    apb(1'b1, `GRANT_PEND_ADDR, bits);
    settle();
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`SRC_LATCH_ADDR, 32'h00000000);
    rd_chk(`FAST_SEL_ADDR, 32'h00000000);
    rd_chk(`MASK_ADDR, 32'hffffffff);
    rd_chk(`PRIORITY_ADDR, 32'h0000007f);
    rd_chk(32'h4a000018, 32'h00000000);
    check({31'h0, err}, 32'h1);
    u_src.pulse(32'h00000028);
    settle();
    rd_chk(`SRC_LATCH_ADDR, 32'h00000028);
    check({31'h0, normal_irq}, 32'h0);
    apb(1'b1, `SRC_LATCH_ADDR, 32'h00000008);
    rd_chk(`SRC_LATCH_ADDR, 32'h00000020);
    apb(1'b1, `SRC_LATCH_ADDR, 32'hffffffff);
    apb(1'b1, `MASK_ADDR, 32'h00000000);
    u_src.pulse(32'h00000416);
    settle();
    rd_chk(`GRANT_PEND_ADDR, 32'h00000002);
    rd_chk(`GRANT_INDEX_ADDR, 32'h00000001);
    rd_chk(`PRIORITY_ADDR, 32'h0000017f);
    rd_chk(`SRC_LATCH_ADDR, 32'h00000416);
    check({31'h0, normal_irq}, 32'h1);
    prev = 32'h00000002;
    for (int i = 0; i < 3; i++) begin
      service(prev);
      rd_chk(`GRANT_PEND_ADDR, exp_bit[i]);
      rd_chk(`GRANT_INDEX_ADDR, exp_idx[i]);
      rd_chk(`PRIORITY_ADDR, exp_pri[i]);
      prev = exp_bit[i];
    end
    apb(1'b1, `GRANT_PEND_ADDR, 32'h00000400);
    settle();
    rd_chk(`GRANT_PEND_ADDR, 32'h00000400);
    service(32'h00000400);
    check({31'h0, normal_irq}, 32'h0);
    apb(1'b1, `PRIORITY_ADDR, 32'h00000600);
    u_src.pulse(32'h00000210);
    settle();
    rd_chk(`GRANT_PEND_ADDR, 32'h00000010);
    service(32'h00000010);
    rd_chk(`GRANT_PEND_ADDR, 32'h00000200);
    rd_chk(`PRIORITY_ADDR, 32'h00000600);
    service(32'h00000200);
    apb(1'b1, `FAST_SEL_ADDR, 32'h00000020);
    u_src.pulse(32'h00000020);
    settle();
    check({31'h0, fast_irq}, 32'h1);
    rd_chk(`GRANT_PEND_ADDR, 32'h00000000);
    check({31'h0, normal_irq}, 32'h0);
    apb(1'b1, `SRC_LATCH_ADDR, 32'h00000020);
    settle();
    check({31'h0, fast_irq}, 32'h0);
    apb(1'b1, `FAST_SEL_ADDR, 32'h00000000);
    apb(1'b1, `PRIORITY_ADDR, 32'h0018007f);
    u_src.pulse(32'h00410000);
    settle();
    rd_chk(`GRANT_PEND_ADDR, 32'h00400000);
    rd_chk(`PRIORITY_ADDR, 32'h0000007f);
    service(32'h00400000);
    rd_chk(`GRANT_PEND_ADDR, 32'h00010000);
    rd_chk(`PRIORITY_ADDR, 32'h0018007f);
    service(32'h00010000);
    report_and_stop();
  end
endmodule
